// *** rtl/sfh_pkg.sv ***
// shared constants and types of the serial flash command front end
// assumes a 100 MHz system clock that oversamples the host serial pins
package sfh_pkg;

  // opcodes, single data line
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb; // dual_io_read_cmd
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb; // quad_io_read_cmd
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_READ_CONFIG = 8'h15; // read_config_cmd
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h38;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02; // page_program_cmd
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_POWER_UP = 8'hab;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hb0;
  localparam logic [7:0] OP_RESUME_A = 8'h7a;
  localparam logic [7:0] OP_RESUME_B = 8'h30;

  // field positions and counts
  localparam int unsigned CFG_DUMMY_SEL_BIT = 6; // dummy_cycle_select
  localparam logic [4:0] OPCODE_CLKS = 5'd8;
  localparam logic [3:0] DUMMY_FIXED = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_SEL0 = 4'h4;
  localparam logic [3:0] DUMMY_DUAL_SEL1 = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_SEL0 = 4'h6;
  localparam logic [3:0] DUMMY_QUAD_SEL1 = 4'ha;
  localparam logic [4:0] ADDR_CLKS_X1 = 5'd24;
  localparam logic [4:0] ADDR_CLKS_X2 = 5'd12;
  localparam logic [4:0] ADDR_CLKS_X4 = 5'd6;

  // reset values; pin vector is {hold_n, cs_n, sclk, io[3:0]}
  localparam logic [6:0] PIN_RST = 7'h60;
  localparam logic [3:0] IO_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_WAIT, ST_IGNORE
  } sfh_state_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
  } sfh_cmd_type;

  typedef struct packed {
    logic known;
    logic is_read;
    logic has_addr;
    logic has_wdata;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
    logic [3:0] dummy;
  } sfh_opinfo_type;

endpackage : sfh_pkg

// *** rtl/sfh_sync.sv ***
// three-stage pin synchroniser, one stage set per bit
// assumes asynchronous pins; a change is taken once stages two and three agree
`timescale 1ns/1ps
module sfh_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [WIDTH-1:0] d_i, // raw pins
  output logic [WIDTH-1:0] q_o // filtered levels
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_q, s2_q, s3_q, v_q;
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          s1_q <= RST_VAL[g];
          s2_q <= RST_VAL[g];
          s3_q <= RST_VAL[g];
          v_q <= RST_VAL[g];
        end else begin
          s1_q <= d_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            v_q <= s3_q;
          end
        end
      end
      assign q_o[g] = v_q;
    end
  endgenerate
endmodule : sfh_sync

// *** rtl/sfh_front.sv ***
// serial flash command front end: pause handling and opcode decode
// assumes host pins arrive asynchronously; array, status and config live outside
`timescale 1ns/1ps
// Contract
// - pause low while selected freezes all serial traffic, clocks ignored.
// - pause never aborts a running status write, program or erase.
// - pause starts on pause low with select low, only while clock low.
// - pause ends on pause high, only while clock low.
// - data output floats from pause low until pause high.
// - data input ignored while clock and pause both low, until released.
// - select high during pause resets the serial logic, dropping the command.
// - pause ignored in quad mode.
// - dual and quad io reads take dummy count from config bit six.
// - opcode 02h with three address bytes programs the addressed page.
// - opcode 15h shifts out the configuration register, no address.
// - unknown opcode: standby, output floating, until next select fall.
// - inputs sampled on clock rise, outputs change on fall; modes 0 and 3.
// - non-read commands execute only if select rises on a byte boundary.
module sfh_front (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic sclk_i, // host serial clock pin
  input wire logic cs_n_i, // chip select pin, low active
  input wire logic hold_n_i, // pause pin, low active
  input wire logic [3:0] io_i, // data pins in; io0 is the single data input
  input wire logic quad_mode_i, // quad io mode enabled
  input wire logic [7:0] cfg_reg_i, // configuration register value
  input wire logic [7:0] status_reg_i, // status register value
  input wire logic [7:0] rd_byte_i, // array byte at the current read address
  output logic [3:0] io_o, // data pins out; io1 is the single data output
  output logic [3:0] io_oe_o, // data pin drive enables
  output sfh_pkg::sfh_cmd_type cmd_o, // decoded opcode and address
  output logic cmd_exec_o, // non-read command accepted, pulse
  output logic cmd_reject_o, // non-read command rejected, pulse
  output logic wdata_valid_o, // data byte received, pulse
  output logic [7:0] wdata_o, // received data byte
  output logic rd_start_o, // array read address valid on cmd_o, pulse
  output logic rd_next_o, // array byte consumed, pulse
  output logic hold_active_o // pause in force
);

  logic [6:0] pin_s;
  logic sclk_s, cs_s, hold_n_s;
  logic [3:0] io_s;

  sfh_sync #(.WIDTH(7), .RST_VAL(sfh_pkg::PIN_RST)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i({hold_n_i, cs_n_i, sclk_i, io_i}),
    .q_o(pin_s)
  );
  assign hold_n_s = pin_s[6];
  assign cs_s = pin_s[5];
  assign sclk_s = pin_s[4];
  assign io_s = pin_s[3:0];

  function automatic sfh_pkg::sfh_opinfo_type op_decode(input logic [7:0] op, input logic dc);
    sfh_pkg::sfh_opinfo_type r;
    r = '0;
    r.known = 1'b1;
    r.addr_lanes = 3'd1;
    r.data_lanes = 3'd1;
    case (op)
      sfh_pkg::OP_READ: begin
        r.is_read = 1'b1; r.has_addr = 1'b1;
      end
      sfh_pkg::OP_FAST_READ: begin
        r.is_read = 1'b1; r.has_addr = 1'b1; r.dummy = sfh_pkg::DUMMY_FIXED;
      end
      sfh_pkg::OP_DUAL_OUT_READ: begin
        r.is_read = 1'b1; r.has_addr = 1'b1; r.dummy = sfh_pkg::DUMMY_FIXED; r.data_lanes = 3'd2;
      end
      sfh_pkg::OP_QUAD_OUT_READ: begin
        r.is_read = 1'b1; r.has_addr = 1'b1; r.dummy = sfh_pkg::DUMMY_FIXED; r.data_lanes = 3'd4;
      end
      sfh_pkg::OP_DUAL_IO_READ: begin
        r.is_read = 1'b1; r.has_addr = 1'b1; r.addr_lanes = 3'd2; r.data_lanes = 3'd2;
        r.dummy = dc ? sfh_pkg::DUMMY_DUAL_SEL1 : sfh_pkg::DUMMY_DUAL_SEL0;
      end
      sfh_pkg::OP_QUAD_IO_READ: begin
        r.is_read = 1'b1; r.has_addr = 1'b1; r.addr_lanes = 3'd4; r.data_lanes = 3'd4;
        r.dummy = dc ? sfh_pkg::DUMMY_QUAD_SEL1 : sfh_pkg::DUMMY_QUAD_SEL0;
      end
      sfh_pkg::OP_READ_STATUS, sfh_pkg::OP_READ_CONFIG: r.is_read = 1'b1;
      sfh_pkg::OP_WRITE_STATUS: r.has_wdata = 1'b1;
      sfh_pkg::OP_PAGE_PROGRAM: begin
        r.has_addr = 1'b1; r.has_wdata = 1'b1;
      end
      sfh_pkg::OP_QUAD_PROGRAM: begin
        r.has_addr = 1'b1; r.has_wdata = 1'b1; r.data_lanes = 3'd4;
      end
      sfh_pkg::OP_SECTOR_ERASE, sfh_pkg::OP_BLOCK32_ERASE, sfh_pkg::OP_BLOCK64_ERASE: r.has_addr = 1'b1;
      sfh_pkg::OP_WRITE_ENABLE, sfh_pkg::OP_WRITE_DISABLE, sfh_pkg::OP_CHIP_ERASE_A,
      sfh_pkg::OP_CHIP_ERASE_B, sfh_pkg::OP_POWER_DOWN, sfh_pkg::OP_POWER_UP,
      sfh_pkg::OP_SUSPEND_A, sfh_pkg::OP_SUSPEND_B, sfh_pkg::OP_RESUME_A,
      sfh_pkg::OP_RESUME_B: r.known = 1'b1;
      default: r.known = 1'b0;
    endcase
    return r;
  endfunction : op_decode

  sfh_pkg::sfh_state_type state_q, state_d, post_op_st, post_addr_st;
  sfh_pkg::sfh_opinfo_type info_q, op_info_w;
  sfh_pkg::sfh_cmd_type cmd_q;
  logic [4:0] cnt_q, cnt_d, cnt_inc, addr_clks;
  logic [23:0] sh_q, sh_shift;
  logic [2:0] bitmod_q, bitmod_nx, in_lanes, out_lanes, ocnt_q, ocnt_nx;
  logic [7:0] out_sh_q, out_src, out_data, out_shift;
  logic [3:0] io_o_q, io_oe_q, io_oe_d, drive_w, lane_mask;
  logic sclk_prev_q, cs_prev_q, hold_q, drv_q;
  logic exec_q, reject_q, wv_q, rds_q, rdn_q;
  logic [7:0] wd_q;

  // edges found by oversampling the filtered clock; mode 3 idles high, so its first
  // edge is a fall, which no phase but read data acts on
  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire cs_rise = cs_s & ~cs_prev_q;
  wire hold_en = ~quad_mode_i;
  wire active = ~cs_s & ~hold_q;
  wire rise_en = sclk_rise & active & (state_q != sfh_pkg::ST_IGNORE);
  wire fall_en = sclk_fall & active & (state_q == sfh_pkg::ST_RDATA);
  wire array_read = info_q.is_read && (cmd_q.opcode != sfh_pkg::OP_READ_STATUS)
                    && (cmd_q.opcode != sfh_pkg::OP_READ_CONFIG);
  wire so_float = hold_en & ~hold_n_s;
  wire exec_ok = ((state_q == sfh_pkg::ST_WAIT) || (state_q == sfh_pkg::ST_WDATA))
                 && (bitmod_q == 3'd0) && !hold_q;
  wire nonread_pend = ((state_q == sfh_pkg::ST_ADDR) && !info_q.is_read)
                      || (state_q == sfh_pkg::ST_WAIT) || (state_q == sfh_pkg::ST_WDATA);
  wire addr_done = (state_q == sfh_pkg::ST_ADDR) && (cnt_inc == addr_clks);
  wire byte_done = (state_q == sfh_pkg::ST_WDATA) && (bitmod_nx == 3'd0);

  assign in_lanes = (state_q == sfh_pkg::ST_ADDR) ? info_q.addr_lanes :
                    (state_q == sfh_pkg::ST_WDATA) ? info_q.data_lanes : 3'd1;
  assign sh_shift = (in_lanes == 3'd4) ? {sh_q[19:0], io_s} :
                    (in_lanes == 3'd2) ? {sh_q[21:0], io_s[1:0]} : {sh_q[22:0], io_s[0]};
  assign addr_clks = (info_q.addr_lanes == 3'd4) ? sfh_pkg::ADDR_CLKS_X4 :
                     (info_q.addr_lanes == 3'd2) ? sfh_pkg::ADDR_CLKS_X2 : sfh_pkg::ADDR_CLKS_X1;
  assign cnt_inc = cnt_q + 5'd1;
  assign bitmod_nx = bitmod_q + in_lanes;
  assign op_info_w = op_decode(sh_shift[7:0], cfg_reg_i[sfh_pkg::CFG_DUMMY_SEL_BIT]);
  assign post_op_st = op_info_w.has_addr ? sfh_pkg::ST_ADDR :
                      (op_info_w.is_read ? sfh_pkg::ST_RDATA :
                      (op_info_w.has_wdata ? sfh_pkg::ST_WDATA : sfh_pkg::ST_WAIT));
  assign post_addr_st = (info_q.dummy != 4'h0) ? sfh_pkg::ST_DUMMY :
                        (info_q.is_read ? sfh_pkg::ST_RDATA :
                        (info_q.has_wdata ? sfh_pkg::ST_WDATA : sfh_pkg::ST_WAIT));

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_inc;
    case (state_q)
      sfh_pkg::ST_OPCODE: begin
        if (cnt_inc == sfh_pkg::OPCODE_CLKS) begin
          cnt_d = 5'd0;
          state_d = op_info_w.known ? post_op_st : sfh_pkg::ST_IGNORE;
        end
      end
      sfh_pkg::ST_ADDR: begin
        if (addr_done) begin
          cnt_d = 5'd0;
          state_d = post_addr_st;
        end
      end
      sfh_pkg::ST_DUMMY: begin
        if (cnt_inc == {1'b0, info_q.dummy}) begin
          cnt_d = 5'd0;
          state_d = sfh_pkg::ST_RDATA;
        end
      end
      sfh_pkg::ST_RDATA, sfh_pkg::ST_WDATA, sfh_pkg::ST_WAIT, sfh_pkg::ST_IGNORE: cnt_d = cnt_q;
      default: state_d = sfh_pkg::ST_IGNORE;
    endcase
  end

  // select high clears state, count and bit position, paused or not; a fresh select fall restarts at the opcode
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || cs_s) begin
      state_q <= sfh_pkg::ST_OPCODE;
      cnt_q <= 5'd0;
      bitmod_q <= 3'd0;
    end else if (rise_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bitmod_q <= bitmod_nx;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sh_q <= 24'h0;
      info_q <= '0;
      cmd_q <= '0;
    end else if (rise_en) begin
      sh_q <= sh_shift;
      if (state_q == sfh_pkg::ST_OPCODE && cnt_inc == sfh_pkg::OPCODE_CLKS) begin
        info_q <= op_info_w;
        cmd_q.opcode <= sh_shift[7:0];
      end
      if (addr_done) begin
        cmd_q.addr <= sh_shift;
      end
    end
  end

  // the pause only gates the serial side; array operations already started downstream
  // see no signal from it and run on
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || cs_s || !hold_en) begin
      hold_q <= 1'b0;
    end else if (!hold_q && !hold_n_s && !sclk_s) begin
      hold_q <= 1'b1;
    end else if (hold_q && hold_n_s && !sclk_s) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
    end
  end

  // read data path: a new byte is fetched when the previous one is fully shifted out
  assign out_lanes = info_q.data_lanes;
  assign out_src = (cmd_q.opcode == sfh_pkg::OP_READ_STATUS) ? status_reg_i :
                   (cmd_q.opcode == sfh_pkg::OP_READ_CONFIG) ? cfg_reg_i : rd_byte_i;
  assign out_data = (ocnt_q == 3'd0) ? out_src : out_sh_q;
  assign ocnt_nx = ocnt_q + out_lanes;
  assign out_shift = (out_lanes == 3'd4) ? {out_data[3:0], 4'h0} :
                     (out_lanes == 3'd2) ? {out_data[5:0], 2'b00} : {out_data[6:0], 1'b0};
  assign drive_w = (out_lanes == 3'd4) ? out_data[7:4] :
                   (out_lanes == 3'd2) ? {2'b00, out_data[7:6]} : {2'b00, out_data[7], 1'b0};
  assign lane_mask = (out_lanes == 3'd4) ? 4'hf : (out_lanes == 3'd2) ? 4'h3 : 4'h2;
  assign io_oe_d = (drv_q && !cs_s && !so_float && state_q == sfh_pkg::ST_RDATA) ? lane_mask : 4'h0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || cs_s) begin
      out_sh_q <= 8'h0;
      ocnt_q <= 3'd0;
      io_o_q <= sfh_pkg::IO_RST;
      drv_q <= 1'b0;
    end else if (fall_en) begin
      out_sh_q <= out_shift;
      ocnt_q <= ocnt_nx;
      io_o_q <= drive_w;
      drv_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      io_oe_q <= 4'h0;
      exec_q <= 1'b0;
      reject_q <= 1'b0;
      wv_q <= 1'b0;
      wd_q <= 8'h0;
      rds_q <= 1'b0;
      rdn_q <= 1'b0;
    end else begin
      io_oe_q <= io_oe_d;
      exec_q <= cs_rise && exec_ok;
      reject_q <= cs_rise && nonread_pend && !exec_ok;
      wv_q <= rise_en && byte_done;
      wd_q <= (rise_en && byte_done) ? sh_shift[7:0] : wd_q;
      rds_q <= rise_en && (state_d == sfh_pkg::ST_RDATA) && (state_q != sfh_pkg::ST_RDATA)
               && (state_q != sfh_pkg::ST_OPCODE) && array_read;
      rdn_q <= fall_en && (ocnt_q == 3'd0) && array_read;
    end
  end

  assign io_o = io_o_q;
  assign io_oe_o = io_oe_q;
  assign cmd_o = cmd_q;
  assign cmd_exec_o = exec_q;
  assign cmd_reject_o = reject_q;
  assign wdata_valid_o = wv_q;
  assign wdata_o = wd_q;
  assign rd_start_o = rds_q;
  assign rd_next_o = rdn_q;
  assign hold_active_o = hold_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  hold_entry_a: assert property ($rose(hold_q) |-> $past(!sclk_s && !hold_n_s && !cs_s))
    else $error("pause began without select low, clock low and pause low");
  hold_exit_a: assert property (($fell(hold_q) && $past(!cs_s && !quad_mode_i)) |-> $past(hold_n_s && !sclk_s))
    else $error("pause ended without pause high while clock low");
  so_float_a: assert property ((!cs_s && !hold_n_s && !quad_mode_i) |=> io_oe_o == 4'h0)
    else $error("data output driven while pause low");
  hold_freeze_a: assert property ((hold_q && !cs_s) |=> $stable({state_q, cnt_q, sh_q, out_sh_q}))
    else $error("transfer state moved during pause");
  quad_nohold_a: assert property (quad_mode_i |=> !hold_q)
    else $error("pause active in quad mode");
  cs_reset_a: assert property (cs_rise |=> state_q == sfh_pkg::ST_OPCODE && cnt_q == 5'd0 && !hold_q)
    else $error("select high did not reset the serial logic");
  ignore_float_a: assert property ((state_q == sfh_pkg::ST_IGNORE) |=> io_oe_o == 4'h0)
    else $error("output driven after unknown opcode");
  exec_bound_a: assert property (cmd_exec_o |-> $past(cs_rise) && $past(bitmod_q) == 3'd0)
    else $error("command executed off a byte boundary");
  cfg_out_a: assert property ((fall_en && ocnt_q == 3'd0 && cmd_q.opcode == sfh_pkg::OP_READ_CONFIG)
                              |=> io_o[1] == $past(cfg_reg_i[7]))
    else $error("configuration read did not start with its top bit");
  out_edge_a: assert property (($changed(io_o_q) && $past(!cs_s) && !cs_s) |-> $past(fall_en))
    else $error("output data changed away from a clock fall");

  hold_cycle_c: cover property ($rose(hold_q) ##[1:400] $fell(hold_q) && !cs_s);
  prog_exec_c: cover property (cmd_exec_o && cmd_q.opcode == sfh_pkg::OP_PAGE_PROGRAM);
  reject_c: cover property (cmd_reject_o);
  cfg_read_c: cover property (fall_en && cmd_q.opcode == sfh_pkg::OP_READ_CONFIG);

endmodule : sfh_front

// *** tb/sfh_host.sv ***
// host-side model of the serial link: select, serial clock, pause and data lanes
// assumes the bench calls its tasks; every pin changes at a sys_clk_i fall
`timescale 1ns/1ps
module sfh_host (
  input wire logic sys_clk_i, // system clock
  output logic sclk_o, // serial clock
  output logic cs_n_o, // select, low active
  output logic hold_n_o, // pause, low active
  output logic [3:0] io_o // data lanes from the host
);
  logic mode3;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    hold_n_o = 1'b1;
    io_o = 4'h5;
    mode3 = 1'b0;
  end
  // half of the 80 ns link period
  task automatic half();
    repeat (4) @(negedge sys_clk_i);
  endtask : half
  // data set at the fall, taken at the rise; undriven lanes toggle so stale values never match
  task automatic tick(input logic [3:0] d, input logic [3:0] en);
    sclk_o = 1'b0;
    io_o = (d & en) | (~io_o & ~en);
    half();
    sclk_o = 1'b1;
    half();
  endtask : tick
  task automatic bits(input logic [31:0] v, input int n, input int w);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    for (int k = n - 1; k >= 0; k--) begin
      tick(4'(v >> (k * w)) & m, m);
    end
  endtask : bits
  task automatic sel(input logic m3);
    mode3 = m3;
    sclk_o = m3;
    half();
    cs_n_o = 1'b0;
    half();
  endtask : sel
  // select rises after whole clocks only; a partial byte is the caller's deliberate choice
  task automatic desel();
    if (!mode3) begin
      sclk_o = 1'b0;
      half();
    end
    cs_n_o = 1'b1;
    io_o = ~io_o;
    half();
    half();
  endtask : desel
  // pause enters and leaves only with the clock low
  task automatic pause(input logic on);
    sclk_o = 1'b0;
    hold_n_o = !on;
    half();
    half();
  endtask : pause
endmodule : sfh_host

// *** tb/sfh_front_test.sv ***
// self-checking bench of the command front end against the host model
// assumes pins resolve as device drive where enabled, host lanes elsewhere
`timescale 1ns/1ps
module sfh_front_test;
  logic sys_clk_i = 1'b0;
  logic rst_i;
  logic sclk, cs_n, hold_n, quad_mode;
  logic [3:0] h_io, io_in, io_out, io_oe, m;
  logic [7:0] cfg_reg, status_reg, rd_byte, wdata, exp8;
  logic [7:0] ers [4] = '{8'h20, 8'h52, 8'hd8, 8'h01};
  logic [7:0] rds [4] = '{8'h03, 8'h0b, 8'h3b, 8'h6b};
  logic [7:0] ops [10] = '{8'h06, 8'h04, 8'h60, 8'hc7, 8'hb9, 8'hab, 8'h75, 8'hb0, 8'h7a, 8'h30};
  sfh_pkg::sfh_cmd_type cmd;
  logic cmd_exec, cmd_reject, wdata_valid, rd_start, rd_next, hold_active;
  logic [31:0] seed = 32'h6a1b;
  logic [23:0] addr;
  logic [9:0] notes [$];
  logic [9:0] got, expn;
  int miscompares = 0;
  int check_count = 0;
  int n, w;
  always #5 sys_clk_i = ~sys_clk_i;
  assign io_in = (io_oe & io_out) | (~io_oe & h_io);
  sfh_host u_sfh_host (.sys_clk_i(sys_clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .hold_n_o(hold_n), .io_o(h_io));
  sfh_front u_sfh_front (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .hold_n_i(hold_n), .io_i(io_in), .quad_mode_i(quad_mode), .cfg_reg_i(cfg_reg),
    .status_reg_i(status_reg), .rd_byte_i(rd_byte), .io_o(io_out), .io_oe_o(io_oe), .cmd_o(cmd),
    .cmd_exec_o(cmd_exec), .cmd_reject_o(cmd_reject), .wdata_valid_o(wdata_valid), .wdata_o(wdata),
    .rd_start_o(rd_start), .rd_next_o(rd_next), .hold_active_o(hold_active));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // every pulse takes the oldest note; a pulse with no note pending is a mismatch too
  always @(negedge sys_clk_i) begin
    if (!rst_i && (cmd_exec === 1'b1 || cmd_reject === 1'b1 || wdata_valid === 1'b1
                   || rd_start === 1'b1 || rd_next === 1'b1)) begin
      got = cmd_exec ? {2'd1, cmd.opcode} : (cmd_reject ? {2'd2, 8'h00} : (wdata_valid ? {2'd3, wdata} :
            (rd_start ? {2'd0, cmd.addr[7:0]} : {2'd0, rd_byte})));
      expn = (notes.size() > 0) ? notes.pop_front() : 10'h3ff;
      chk("result", expn, got);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    rst_i = 1'b1;
    quad_mode = 1'b0;
    cfg_reg = 8'(rnd());
    status_reg = 8'(rnd());
    rd_byte = 8'(rnd());
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    // unknown opcode: nothing driven, no pulse at select rise
    u_sfh_host.sel(1'b0);
    u_sfh_host.bits(32'hff, 8, 1);
    u_sfh_host.bits(rnd(), 8, 1);
    chk("standby drive", 0, io_oe);
    u_sfh_host.desel();
    // every plain command, alternating clock modes
    for (int i = 0; i < 10; i++) begin
      u_sfh_host.sel(i[0]);
      u_sfh_host.bits(32'(ops[i]), 8, 1);
      notes.push_back({2'd1, ops[i]});
      u_sfh_host.desel();
    end
    // one bit past the byte boundary
    u_sfh_host.sel(1'b0);
    u_sfh_host.bits(32'h0d, 9, 1);
    notes.push_back({2'd2, 8'h00});
    u_sfh_host.desel();
    // single and quad lane page program
    for (int j = 0; j < 2; j++) begin
      addr = 24'(rnd());
      exp8 = 8'(rnd());
      w = j ? 4 : 1;
      u_sfh_host.sel(1'b0);
      u_sfh_host.bits(j ? 32'h38 : 32'h02, 8, 1);
      u_sfh_host.bits(32'(addr), 24, 1);
      u_sfh_host.half();
      chk("address", 32'(addr), 32'(cmd.addr));
      u_sfh_host.bits(32'(exp8), 8 / w, w);
      notes.push_back({2'd3, exp8});
      notes.push_back({2'd1, j ? 8'h38 : 8'h02});
      u_sfh_host.desel();
    end
    // erases take an address, the status write a data byte; both accepted on a whole byte
    for (int j = 0; j < 4; j++) begin
      exp8 = 8'(rnd());
      u_sfh_host.sel(1'b0);
      u_sfh_host.bits(32'(ers[j]), 8, 1);
      u_sfh_host.bits((j < 3) ? rnd() : 32'(exp8), (j < 3) ? 24 : 8, 1);
      if (j == 3) notes.push_back({2'd3, exp8});
      notes.push_back({2'd1, ers[j]});
      u_sfh_host.desel();
    end
    // status and configuration reads, then the output floats under pause
    cfg_reg = 8'(rnd());
    status_reg = 8'(rnd());
    for (int j = 0; j < 2; j++) begin
      exp8 = j ? cfg_reg : status_reg;
      u_sfh_host.sel(j[0]);
      u_sfh_host.bits(j ? 32'h15 : 32'h05, 8, 1);
      for (int k = 7; k >= 0; k--) begin
        u_sfh_host.tick(4'h0, 4'h0);
        chk("read bit", 32'(exp8[k]), 32'(io_out[1]));
      end
      chk("read drive", 1, io_oe[1]);
      u_sfh_host.pause(1'b1);
      chk("drive in pause", 0, io_oe);
      u_sfh_host.pause(1'b0);
      u_sfh_host.desel();
    end
    // dummy clock counts follow config bit six
    for (int j = 0; j < 4; j++) begin
      cfg_reg[sfh_pkg::CFG_DUMMY_SEL_BIT] = j[0];
      rd_byte = 8'(rnd());
      addr = 24'(rnd());
      w = j[1] ? 4 : 2;
      m = j[1] ? 4'hf : 4'h3;
      n = j[1] ? (j[0] ? int'(sfh_pkg::DUMMY_QUAD_SEL1) : int'(sfh_pkg::DUMMY_QUAD_SEL0))
               : (j[0] ? int'(sfh_pkg::DUMMY_DUAL_SEL1) : int'(sfh_pkg::DUMMY_DUAL_SEL0));
      u_sfh_host.sel(1'b0);
      u_sfh_host.bits(j[1] ? 32'heb : 32'hbb, 8, 1);
      u_sfh_host.bits(32'(addr), 24 / w, w);
      notes.push_back({2'd0, addr[7:0]});
      notes.push_back({2'd0, rd_byte});
      repeat (n) u_sfh_host.tick(4'h0, 4'h0);
      chk("early drive", 0, io_oe);
      u_sfh_host.tick(4'h0, 4'h0);
      chk("lanes", 32'(m), 32'(io_oe));
      chk("first data", 32'(rd_byte >> (8 - w)), 32'(io_out & m));
      u_sfh_host.desel();
    end
    // single-lane address reads: no dummy for 03h, a fixed dummy count otherwise, data on one, two or four lanes
    for (int j = 0; j < 4; j++) begin
      rd_byte = 8'(rnd());
      addr = 24'(rnd());
      w = (j == 3) ? 4 : (j == 2) ? 2 : 1;
      m = (j == 3) ? 4'hf : (j == 2) ? 4'h3 : 4'h2;
      u_sfh_host.sel(1'b0);
      u_sfh_host.bits(32'(rds[j]), 8, 1);
      u_sfh_host.bits(32'(addr), 24, 1);
      notes.push_back({2'd0, addr[7:0]});
      notes.push_back({2'd0, rd_byte});
      repeat (j ? int'(sfh_pkg::DUMMY_FIXED) : 0) u_sfh_host.tick(4'h0, 4'h0);
      u_sfh_host.tick(4'h0, 4'h0);
      chk("read lanes", 32'(m), 32'(io_oe));
      chk("read data", (j < 2) ? 32'(rd_byte[7]) << 1 : 32'(rd_byte >> (8 - w)), 32'(io_out & m));
      u_sfh_host.desel();
    end
    // pause mid-opcode: entry waits for a low clock, clocks in pause are ignored
    u_sfh_host.sel(1'b0);
    u_sfh_host.bits(32'h0, 4, 1);
    u_sfh_host.hold_n_o = 1'b0;
    u_sfh_host.half();
    u_sfh_host.half();
    chk("pause with clock high", 0, hold_active);
    u_sfh_host.pause(1'b1);
    chk("pause", 1, hold_active);
    u_sfh_host.bits(32'h7, 3, 1);
    u_sfh_host.pause(1'b0);
    chk("pause end", 0, hold_active);
    u_sfh_host.bits(32'h6, 4, 1);
    notes.push_back({2'd1, 8'h06});
    u_sfh_host.desel();
    // select rise in pause drops the pending command
    u_sfh_host.sel(1'b0);
    u_sfh_host.bits(32'h02, 8, 1);
    u_sfh_host.bits(32'h0, 4, 1);
    u_sfh_host.pause(1'b1);
    notes.push_back({2'd2, 8'h00});
    u_sfh_host.desel();
    u_sfh_host.pause(1'b0);
    // quad mode ignores the pause pin
    quad_mode = 1'b1;
    u_sfh_host.sel(1'b0);
    u_sfh_host.bits(32'h0, 4, 1);
    u_sfh_host.pause(1'b1);
    chk("pause in quad", 0, hold_active);
    u_sfh_host.bits(32'h6, 4, 1);
    notes.push_back({2'd1, 8'h06});
    u_sfh_host.desel();
    u_sfh_host.pause(1'b0);
    quad_mode = 1'b0;
    u_sfh_host.half();
    chk("pending notes", 0, notes.size());
    tally_and_finish();
  end
endmodule : sfh_front_test
